// file: design/cwr_handler.sv
// Write configuration reference command handler with echo or exception answer.
`timescale 1ns/10ps
// Overview of operation
// - Accept write command code 15 hex.
// - Config items to nonvolatile store, override to RAM.
// - Digital items integer, analog items float.
// - Successful write answered by exact echo.
// - Register address names the parameter tag.
// - Infrared: three C0 before, FF after.
// - Reference type must be 06.
// - Only file number 3 supported.
// - Low byte tag, high byte loop/extension.
// - High byte 00,01,40,41 select loop/database.
// - Tags 01-7F float, 80-FF integer.
// - Tag 7D is unlimited volatile override.
// - One parameter per write request.
// - Register count 1 integer, 2 float.
// - Keypad editing makes writes answer busy.
module cwr_handler (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Received request bytes, CRC already checked by the link.
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_byte,
	input wire logic rx_end,
	// Answer bytes.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_byte,
	output logic tx_last,
	// Static settings and keypad status.
	input wire logic [7:0] dev_addr,
	input wire logic ir_mode,
	input wire logic keypad_busy,
	// Nonvolatile configuration store write port.
	output logic nv_wr,
	output logic nv_loop,
	output logic nv_ext,
	output logic [7:0] nv_tag,
	output logic nv_float,
	output logic [31:0] nv_data,
	// Volatile computer setpoint overrides.
	output logic ovr_wr,
	output logic [31:0] ovr_sp_loop1,
	output logic [31:0] ovr_sp_loop2
);
	import cwr_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cwr_state_t st_ff, nxt_st; // Controller state.
	logic [7:0] buf_ff [CWR_FRAME_MAX], nxt_buf [CWR_FRAME_MAX]; // Request bytes, reused as answer.
	logic [4:0] len_ff, nxt_len, pos_ff, nxt_pos, body_pos, total; // Frame length, answer position and span.
	logic [1:0] skip_ff, nxt_skip, cnt_ff, nxt_cnt; // Infrared start bytes seen and answer buffer fill.
	logic bad_ff, nxt_bad, wp_ff, nxt_wp, rp_ff, nxt_rp; // Frame dropped flag and buffer pointers.
	logic nv_wr_ff, nxt_nv_wr, ovr_wr_ff, nxt_ovr_wr; // One-cycle store strobes.
	logic [42:0] nv_rec_ff, nxt_nv_rec; // Loop, extension, float flag, tag and value of the last write.
	logic [31:0] ovr1_ff, nxt_ovr1, ovr2_ff, nxt_ovr2, wdata; // Overrides per loop and the request value.
	logic [7:0] tag, hi, exc_code, exc_fc, push_byte; // Address bytes, exception code and command, answer byte.
	logic is_flt, hi_ok, ours, fmt_ok; // Verdict terms; the exception code is zero when all pass.
	logic [15:0] exc_crc; // CRC of the exception frame.
	logic push, push_last, pop; // Answer byte into and out of the buffer.
	logic [8:0] mem_ff [2], nxt_mem [2]; // Two-entry answer buffer, last flag on top.

	// One CRC16 step over a byte, reflected polynomial.
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CWR_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	// Field offsets follow the fixed request order, so decode is a plain pick.
	// fixed field order
	assign tag = buf_ff[7];
	assign hi = buf_ff[6];
	assign is_flt = ~tag[7];
	assign hi_ok = (hi == CWR_HI_L1_BASIC) || (hi == CWR_HI_L2_BASIC) ||
		(hi == CWR_HI_L1_EXT) || (hi == CWR_HI_L2_EXT);
	assign ours = !bad_ff && (len_ff > 5'h01) && (buf_ff[0] == dev_addr) && (buf_ff[1] == CWR_FC_WRITE);
	assign fmt_ok = ({buf_ff[8], buf_ff[9]} == (is_flt ? CWR_CNT_FLOAT : CWR_CNT_INT)) &&
		(buf_ff[2] == (is_flt ? CWR_BC_FLOAT : CWR_BC_INT)) &&
		(len_ff == (is_flt ? CWR_LEN_FLOAT : CWR_LEN_INT));
	// Busy is checked first so that the operator always wins over the host.
	always_comb begin
		if (keypad_busy) begin
			exc_code = CWR_EXC_BUSY;
		end else if (buf_ff[3] != CWR_REF_TYPE || {buf_ff[4], buf_ff[5]} != CWR_FILE_NUM ||
			!hi_ok || tag == 8'h00) begin
			exc_code = CWR_EXC_ADDR;
		end else if (!fmt_ok) begin
			exc_code = CWR_EXC_VALUE;
		end else begin
			exc_code = 8'h00;
		end
	end
	assign wdata = is_flt ? {buf_ff[10], buf_ff[11], buf_ff[12], buf_ff[13]} : {16'h0000, buf_ff[10], buf_ff[11]};
	assign exc_fc = buf_ff[1] | CWR_EXC_FLAG;
	assign exc_crc = crc_byte(crc_byte(crc_byte(CWR_CRC_INIT, buf_ff[0]), exc_fc), exc_code);

	// ----------------------------------------------------------------
	// Answer byte source
	// ----------------------------------------------------------------
	// Infrared adds three start bytes and one end byte around the body.
	assign body_pos = ir_mode ? 5'(pos_ff - 5'h03) : pos_ff;
	assign total = ir_mode ? 5'(len_ff + 5'h04) : len_ff;
	assign push_last = (pos_ff == 5'(total - 5'h01));
	assign push_byte = (ir_mode && pos_ff < 5'h03) ? CWR_IR_SOF :
		(ir_mode && push_last) ? CWR_IR_EOF : buf_ff[body_pos[3:0]];
	assign push = (st_ff == CWR_ST_SEND) && (cnt_ff != 2'h2);
	assign rx_ready = (st_ff == CWR_ST_RX);

	// ----------------------------------------------------------------
	// Controller next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_buf = buf_ff;
		nxt_len = len_ff;
		nxt_skip = skip_ff;
		nxt_bad = bad_ff;
		nxt_pos = pos_ff;
		nxt_nv_wr = 1'b0;
		nxt_ovr_wr = 1'b0;
		nxt_nv_rec = nv_rec_ff;
		nxt_ovr1 = ovr1_ff;
		nxt_ovr2 = ovr2_ff;
		case (st_ff)
			// Collect one frame; overlong or badly framed frames are dropped.
			CWR_ST_RX: begin
				if (rx_valid) begin
					if (ir_mode && skip_ff < CWR_IR_SOF_CNT) begin
						nxt_bad = bad_ff | (rx_byte != CWR_IR_SOF);
						nxt_skip = 2'(skip_ff + 2'h1);
					end else if (ir_mode && rx_end) begin
						nxt_bad = bad_ff | (rx_byte != CWR_IR_EOF);
					end else if (len_ff == 5'(CWR_FRAME_MAX)) begin
						nxt_bad = 1'b1;
					end else begin
						nxt_buf[len_ff[3:0]] = rx_byte;
						nxt_len = 5'(len_ff + 5'h01);
					end
					if (rx_end) begin
						nxt_st = CWR_ST_EVAL;
						nxt_skip = 2'h0;
					end
				end
			end
			// Decide and either drop a foreign or bad frame, store and echo, or rewrite the buffer as an exception.
			CWR_ST_EVAL: begin
				nxt_pos = 5'h00;
				if (!ours) begin
					nxt_st = CWR_ST_RX;
					nxt_len = 5'h00;
					nxt_bad = 1'b0;
				end else if (exc_code != 8'h00) begin
					nxt_buf[1] = exc_fc;
					nxt_buf[2] = exc_code;
					nxt_buf[3] = exc_crc[7:0];
					nxt_buf[4] = exc_crc[15:8];
					nxt_len = CWR_EXC_LEN;
					nxt_st = CWR_ST_SEND;
				end else begin
					nxt_nv_rec = {hi[CWR_HI_LOOP_BIT], hi[CWR_HI_EXT_BIT], is_flt, tag, wdata};
					if (tag == CWR_TAG_OVR) begin
						nxt_ovr_wr = 1'b1;
						if (hi[CWR_HI_LOOP_BIT]) begin
							nxt_ovr2 = wdata;
						end else begin
							nxt_ovr1 = wdata;
						end
					end else begin
						nxt_nv_wr = 1'b1;
					end
					nxt_st = CWR_ST_SEND;
				end
			end
			// Feed the answer into the buffer while it has room.
			CWR_ST_SEND: begin
				if (push) begin
					nxt_pos = 5'(pos_ff + 5'h01);
					if (push_last) begin
						nxt_st = CWR_ST_RX;
						nxt_len = 5'h00;
						nxt_bad = 1'b0;
					end
				end
			end
			default: begin
				nxt_st = CWR_ST_RX;
			end
		endcase
	end

	// Controller registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= CWR_ST_RX;
			buf_ff <= '{default: 8'h00};
			len_ff <= 5'h00;
			skip_ff <= 2'h0;
			bad_ff <= 1'b0;
			pos_ff <= 5'h00;
			nv_wr_ff <= 1'b0;
			nv_rec_ff <= 43'h00000000000;
			ovr_wr_ff <= 1'b0;
			ovr1_ff <= 32'h00000000;
			ovr2_ff <= 32'h00000000;
		end else begin
			st_ff <= nxt_st;
			buf_ff <= nxt_buf;
			len_ff <= nxt_len;
			skip_ff <= nxt_skip;
			bad_ff <= nxt_bad;
			pos_ff <= nxt_pos;
			nv_wr_ff <= nxt_nv_wr;
			nv_rec_ff <= nxt_nv_rec;
			ovr_wr_ff <= nxt_ovr_wr;
			ovr1_ff <= nxt_ovr1;
			ovr2_ff <= nxt_ovr2;
		end
	end

	// ----------------------------------------------------------------
	// Two-entry answer buffer
	// ----------------------------------------------------------------
	// A stalled receiver fills it and then holds the controller in its send state.
	assign pop = tx_valid && tx_ready;
	always_comb begin
		nxt_mem = mem_ff;
		nxt_wp = wp_ff;
		nxt_rp = rp_ff;
		if (push) begin
			nxt_mem[wp_ff] = {push_last, push_byte};
			nxt_wp = ~wp_ff;
		end
		if (pop) begin
			nxt_rp = ~rp_ff;
		end
		nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
	end

	// Buffer registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_ff <= '{default: 9'h000};
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			mem_ff <= nxt_mem;
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	assign tx_valid = (cnt_ff != 2'h0);
	assign tx_byte = mem_ff[rp_ff][7:0];
	assign tx_last = mem_ff[rp_ff][8];
	assign nv_wr = nv_wr_ff;
	assign nv_loop = nv_rec_ff[42];
	assign nv_ext = nv_rec_ff[41];
	assign nv_float = nv_rec_ff[40];
	assign nv_tag = nv_rec_ff[39:32];
	assign nv_data = nv_rec_ff[31:0];
	assign ovr_wr = ovr_wr_ff;
	assign ovr_sp_loop1 = ovr1_ff;
	assign ovr_sp_loop2 = ovr2_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	cmd_accept_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(nv_wr || ovr_wr) |-> $past(st_ff == CWR_ST_EVAL) && buf_ff[1] == CWR_FC_WRITE)
		else $error("Write taken for a foreign command.");
	store_split_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(nv_wr || ovr_wr) |-> (ovr_wr != nv_wr) && (ovr_wr == (nv_tag == CWR_TAG_OVR)))
		else $error("Override and nonvolatile write mixed up.");
	ovr_ram_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ovr_wr && nv_loop) |-> ovr_sp_loop2 == nv_data)
		else $error("Loop 2 override not held.");
	fmt_class_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		nv_wr |-> nv_float == !nv_tag[7])
		else $error("Wrong data class for tag.");
	ref_check_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_ff == CWR_ST_EVAL && buf_ff[3] != CWR_REF_TYPE) |=> !nv_wr && !ovr_wr)
		else $error("Bad reference type stored.");
	busy_block_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_ff == CWR_ST_EVAL && ours && keypad_busy) |=> !nv_wr && !ovr_wr && buf_ff[2] == CWR_EXC_BUSY)
		else $error("Write accepted while keypad busy.");
	ir_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(push && ir_mode && pos_ff < 5'h03) |-> push_byte == CWR_IR_SOF && !push_last)
		else $error("Infrared start byte wrong.");
	ir_end_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(push && ir_mode && push_last) |-> push_byte == CWR_IR_EOF)
		else $error("Infrared end byte wrong.");
	echo_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(nv_wr) |-> st_ff == CWR_ST_SEND && len_ff == (nv_float ? CWR_LEN_FLOAT : CWR_LEN_INT))
		else $error("Echo length differs from request.");
	buf_full_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cnt_ff == 2'h2 && !tx_ready) |=> cnt_ff == 2'h2 && $stable(pos_ff))
		else $error("Buffer lost a byte under stall.");
endmodule

// file: pkg/cwr_pkg.sv
// Constants and types for the configuration write request handler.
package cwr_pkg;
	// ----------------------------------------------------------------
	// Request field values
	// ----------------------------------------------------------------
	localparam logic [7:0] CWR_FC_WRITE = 8'h15; // Write configuration reference command.
	localparam logic [7:0] CWR_REF_TYPE = 8'h06; // Only valid reference type.
	localparam logic [15:0] CWR_FILE_NUM = 16'h0003; // Only supported file number.
	localparam logic [15:0] CWR_CNT_INT = 16'h0001; // Register count for integer data.
	localparam logic [15:0] CWR_CNT_FLOAT = 16'h0002; // Register count for float data.
	localparam logic [7:0] CWR_BC_INT = 8'h09; // Byte count field for integer writes.
	localparam logic [7:0] CWR_BC_FLOAT = 8'h0B; // Byte count field for float writes.
	localparam logic [4:0] CWR_LEN_INT = 5'h0E; // Whole integer request including CRC.
	localparam logic [4:0] CWR_LEN_FLOAT = 5'h10; // Whole float request including CRC.
	localparam logic [7:0] CWR_TAG_OVR = 8'h7D; // Computer setpoint override tag.
	// ----------------------------------------------------------------
	// Loop and database extension codes (address high byte)
	// ----------------------------------------------------------------
	localparam logic [7:0] CWR_HI_L1_BASIC = 8'h00;
	localparam logic [7:0] CWR_HI_L2_BASIC = 8'h01;
	localparam logic [7:0] CWR_HI_L1_EXT = 8'h40;
	localparam logic [7:0] CWR_HI_L2_EXT = 8'h41;
	localparam int CWR_HI_LOOP_BIT = 0; // Set for loop 2.
	localparam int CWR_HI_EXT_BIT = 6; // Set for the extended database.
	// ----------------------------------------------------------------
	// Infrared framing, exceptions and CRC
	// ----------------------------------------------------------------
	localparam logic [7:0] CWR_IR_SOF = 8'hC0; // Frame start byte value.
	localparam logic [7:0] CWR_IR_EOF = 8'hFF; // Frame end byte value.
	localparam logic [1:0] CWR_IR_SOF_CNT = 2'h3; // Frame start bytes per message.
	localparam logic [7:0] CWR_EXC_FLAG = 8'h80; // Or-ed into the command of an exception.
	localparam logic [7:0] CWR_EXC_ADDR = 8'h02; // Illegal data address.
	localparam logic [7:0] CWR_EXC_VALUE = 8'h03; // Illegal data value.
	localparam logic [7:0] CWR_EXC_BUSY = 8'h06; // Device busy with keypad editing.
	localparam logic [4:0] CWR_EXC_LEN = 5'h05; // Exception frame length including CRC.
	localparam logic [15:0] CWR_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CWR_CRC_POLY = 16'hA001;
	localparam int CWR_FRAME_MAX = 16; // Largest request kept for the echo.
	// Controller states, one-hot.
	typedef enum logic [2:0] {
		CWR_ST_RX = 3'h1,
		CWR_ST_EVAL = 3'h2,
		CWR_ST_SEND = 3'h4
	} cwr_state_t;
endpackage

// file: verification/cwr_host_model.sv
// Behavioural host master that sends requests and collects the answers.
`timescale 1ns/10ps
module cwr_host_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Request bytes toward the handler.
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_byte,
	output logic rx_end,
	// Answer bytes from the handler.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	// Stall the answer side at random while set.
	input wire logic slow
);
	int seed = 47661; // Own stream, so the stalls repeat from run to run.
	logic [7:0] ans_q[$]; // Answer bytes taken so far.
	int last_cnt; // Bytes taken with the last flag.
	int last_pos; // Position of the last flagged byte.

	// ------------------------------------------------------------
	// Request side
	// ------------------------------------------------------------
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_end = 1'b0;
	end

	// one whole frame per call
	// Each byte is held until an edge sees ready; after the last byte the data line is
	// inverted so that a stale byte can never pass for a fresh one.
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(negedge core_clk);
			rx_valid = 1'b1;
			rx_byte = q[i];
			rx_end = (i == q.size() - 1);
			@(posedge core_clk);
			while (rx_ready !== 1'b1) @(posedge core_clk);
		end
		@(negedge core_clk);
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_byte = ~rx_byte;
	endtask

	// ------------------------------------------------------------
	// Answer side
	// ------------------------------------------------------------
	// Half of the cycles stall when slow, enough to fill the two-entry buffer.
	always @(negedge core_clk) begin
		tx_ready <= slow ? (($random(seed) & 1) != 0) : 1'b1;
	end

	// Every accepted byte is kept, with where the last flag fell.
	always @(posedge core_clk) begin
		if (arst_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			ans_q.push_back(tx_byte);
			if (tx_last === 1'b1) begin
				last_cnt++;
				last_pos = ans_q.size();
			end
		end
	end

	// Forget the previous answer before a new request.
	task automatic clear();
		ans_q.delete();
		last_cnt = 0;
		last_pos = 0;
	endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the configuration write request handler.
`timescale 1ns/10ps
module tb;
	import cwr_pkg::*;
	typedef logic [7:0] cwr_bq_t[$];
	logic core_clk, arst_n, rx_valid, rx_ready, rx_end, tx_valid, tx_ready, tx_last;
	logic [7:0] rx_byte, tx_byte, dev_addr, nv_tag;
	logic ir_mode, keypad_busy, slow, nv_wr, nv_loop, nv_ext, nv_float, ovr_wr;
	logic [31:0] nv_data, ovr_sp_loop1, ovr_sp_loop2;
	logic [42:0] nv_cap; // Store outputs seen with the last write pulse.
	logic [7:0] hi_tab[4] = '{CWR_HI_L1_BASIC, CWR_HI_L2_BASIC, CWR_HI_L1_EXT, CWR_HI_L2_EXT};
	int errors, comparisons, cycles, nv_cnt, ovr_cnt, i;
	int seed = 47661;
	logic [7:0] tag;

	// ------------------------------------------------------------
	// Clock, design and host
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	cwr_handler dut (.core_clk, .arst_n, .rx_valid, .rx_ready, .rx_byte, .rx_end, .tx_valid, .tx_ready,
		.tx_byte, .tx_last, .dev_addr, .ir_mode, .keypad_busy, .nv_wr, .nv_loop, .nv_ext, .nv_tag,
		.nv_float, .nv_data, .ovr_wr, .ovr_sp_loop1, .ovr_sp_loop2);
	cwr_host_model host (.core_clk, .arst_n, .rx_valid, .rx_ready, .rx_byte, .rx_end, .tx_valid,
		.tx_ready, .tx_byte, .tx_last, .slow);

	// Store pulses are counted so that a double or missing write shows.
	always @(posedge core_clk) begin
		cycles++;
		if (nv_wr === 1'b1) begin
			nv_cnt++;
			nv_cap = {nv_loop, nv_ext, nv_float, nv_tag, nv_data};
		end
		if (ovr_wr === 1'b1) ovr_cnt++;
		if (cycles == 20000) begin
			errors++;
			$display("[ERR] %0t run did not finish", $time);
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// Expectation functions
	// ------------------------------------------------------------
	function automatic logic [15:0] crc16(input cwr_bq_t q);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[k]) begin
			c = c ^ {8'h00, q[k]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	// Builds a request with its check word, low byte first.
	function automatic cwr_bq_t mk(input logic [7:0] ad, fc, rt, input logic [15:0] fn,
		input logic [7:0] hi, tg, input logic [15:0] cnt, input logic [31:0] d, input int nd);
		cwr_bq_t q;
		logic [15:0] c;
		q = {ad, fc, 8'(7 + nd), rt, fn[15:8], fn[7:0], hi, tg, cnt[15:8], cnt[7:0]};
		if (nd == 4) q = {q, d[31:24], d[23:16]};
		q = {q, d[15:8], d[7:0]};
		c = crc16(q);
		q = {q, c[7:0], c[15:8]};
		return q;
	endfunction

	// A well-formed write whose format follows the tag range.
	function automatic cwr_bq_t ok_req(input logic [7:0] hi, tg, input logic [31:0] d);
		logic fl;
		fl = (tg < 8'h80);
		return mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, hi, tg,
			fl ? CWR_CNT_FLOAT : CWR_CNT_INT, d, fl ? 4 : 2);
	endfunction

	// Infrared framing wraps the whole message.
	function automatic cwr_bq_t frame(input cwr_bq_t q, input logic ir);
		if (ir) q = {CWR_IR_SOF, CWR_IR_SOF, CWR_IR_SOF, q, CWR_IR_EOF};
		return q;
	endfunction

	// Loop, extension, format, tag and value that the store must see.
	function automatic logic [42:0] exp_nv(input cwr_bq_t b);
		logic fl;
		fl = (b.size() == 16);
		return {b[6][0], b[6][6], fl, b[7], fl ? {b[10], b[11], b[12], b[13]} : {16'h0000, b[10], b[11]}};
	endfunction

	// ------------------------------------------------------------
	// Checking tasks
	// ------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	// Code 00 expects an echo, FF no answer, anything else that exception.
	// Store kind: 0 nothing, 1 nonvolatile, 2 override.
	task automatic run(input cwr_bq_t b, input logic [7:0] code, input int st, input logic ir);
		cwr_bq_t e;
		logic [15:0] c;
		logic [42:0] x;
		logic ok;
		int k;
		host.clear();
		nv_cnt = 0;
		ovr_cnt = 0;
		@(negedge core_clk);
		ir_mode = ir;
		host.send(frame(b, ir));
		if (code == 8'hFF) repeat (40) @(posedge core_clk);
		for (k = 0; k < 300 && code != 8'hFF && host.last_cnt == 0; k++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		if (code == 8'h00) e = b;
		if (code != 8'h00 && code != 8'hFF) begin
			e = {b[0], CWR_FC_WRITE | CWR_EXC_FLAG, code};
			c = crc16(e);
			e = {e, c[7:0], c[15:8]};
		end
		if (code != 8'hFF) e = frame(e, ir);
		ok = (host.ans_q.size() == e.size()) && (host.last_pos == e.size());
		foreach (e[k2]) if (ok && host.ans_q[k2] !== e[k2]) ok = 1'b0;
		chk(ok && host.last_cnt == (code != 8'hFF), "answer bytes differ");
		chk(nv_cnt == (st == 1) && ovr_cnt == (st == 2), "store pulse count");
		x = exp_nv(b);
		if (st == 1) chk(nv_cap === x, "store fields");
		if (st == 2) chk((b[6][0] ? ovr_sp_loop2 : ovr_sp_loop1) === x[31:0], "override value");
	endtask

	task automatic wrap_up();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		dev_addr = 8'h02;
		ir_mode = 1'b0;
		keypad_busy = 1'b0;
		slow = 1'b0;
		repeat (8) @(posedge core_clk);
		chk(rx_ready === 1'b1 && tx_valid === 1'b0 && nv_wr === 1'b0, "reset levels");
		@(negedge core_clk);
		arst_n = 1'b1;
		run(ok_req(CWR_HI_L1_BASIC, 8'h01, 32'h3FC00000), 8'h00, 1, 1'b0);
		for (i = 0; i < 4; i++) run(ok_req(hi_tab[i], 8'h80 | 8'($random(seed)), $random(seed)), 8'h00, 1, 1'b0);
		run(ok_req(CWR_HI_L2_BASIC, CWR_TAG_OVR, 32'h42C80000), 8'h00, 2, 1'b0);
		run(ok_req(CWR_HI_L1_EXT, CWR_TAG_OVR, 32'h41A00000), 8'h00, 2, 1'b1);
		chk(ovr_sp_loop2 === 32'h42C80000, "other loop override lost");
		run(ok_req(CWR_HI_L1_EXT, 8'h10, 32'h41200000), 8'h00, 1, 1'b1);
		run(mk(dev_addr, CWR_FC_WRITE, 8'h05, CWR_FILE_NUM, 8'h00, 8'h01, CWR_CNT_FLOAT, 1, 4), CWR_EXC_ADDR, 0, 1'b0);
		run(mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, 16'h000D, 8'h00, 8'h01, CWR_CNT_FLOAT, 1, 4), CWR_EXC_ADDR, 0, 1'b0);
		run(mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, 8'h02, 8'h01, CWR_CNT_FLOAT, 1, 4), CWR_EXC_ADDR, 0, 1'b0);
		run(mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, 8'h00, 8'h00, CWR_CNT_FLOAT, 1, 4), CWR_EXC_ADDR, 0, 1'b0);
		run(mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, 8'h00, 8'h01, CWR_CNT_INT, 1, 4), CWR_EXC_VALUE, 0, 1'b1);
		run(mk(dev_addr, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, 8'h00, 8'h90, CWR_CNT_INT, 1, 4), CWR_EXC_VALUE, 0, 1'b0);
		run(mk(dev_addr, 8'h14, CWR_REF_TYPE, CWR_FILE_NUM, 8'h00, 8'h01, CWR_CNT_FLOAT, 1, 4), 8'hFF, 0, 1'b0);
		run(mk(8'h05, CWR_FC_WRITE, CWR_REF_TYPE, CWR_FILE_NUM, 8'h00, 8'h01, CWR_CNT_FLOAT, 1, 4), 8'hFF, 0, 1'b0);
		@(negedge core_clk);
		keypad_busy = 1'b1;
		run(ok_req(CWR_HI_L1_BASIC, 8'h85, 32'h00001234), CWR_EXC_BUSY, 0, 1'b0);
		@(negedge core_clk);
		keypad_busy = 1'b0;
		// A reset in mid-run must idle both sides and clear the volatile overrides.
		arst_n = 1'b0;
		@(negedge core_clk);
		chk(rx_ready === 1'b1 && tx_valid === 1'b0, "not idle after mid-run reset");
		chk(ovr_sp_loop1 === 32'h0 && ovr_sp_loop2 === 32'h0, "overrides survived reset");
		arst_n = 1'b1;
		slow = 1'b1;
		// Random writes with a stalling receiver and a changing own address.
		for (i = 0; i < 10; i++) begin
			@(negedge core_clk);
			dev_addr = 8'($random(seed)) | 8'h01;
			tag = 8'($random(seed));
			if (tag == 8'h00) tag = 8'h01;
			run(ok_req(hi_tab[i % 4], tag, $random(seed)), 8'h00, (tag == CWR_TAG_OVR) ? 2 : 1, i[0]);
		end
		wrap_up();
	end
endmodule
